/* File: bench/srl_fabric_model.sv */
// Fabric-side model: ties the core hold reset and watches for core activity.
// Assumes the block's core outputs are synchronous to i_clk.
`timescale 1ns/10ps
module srl_fabric_model (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Bench command and block outputs
	input  wire logic       i_release,
	input  wire logic       i_core_rst_n,
	input  wire logic       i_core_boot,
	// Toward block and bench
	output logic            o_hold_n,
	output logic [7:0]      o_activity
);
	// ==========================================
	// Hold tie and activity monitor
	// ==========================================
	// A static tie, so no storage here that an upset could flip
	assign o_hold_n = i_release;
	// Any boot pulse counts as the core having left reset
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_activity <= 8'h00;
		end else if (i_core_boot && i_core_rst_n) begin
			o_activity <= o_activity + 8'h01;
		end
	end
endmodule : srl_fabric_model

/* File: bench/srl_top_tb_top.sv */
// Self-checking bench for the reset isolation and lock block.
// Assumes a fixed flash image set at time zero and the fabric model beside it.
`timescale 1ns/10ps
module srl_top_tb_top;
	// ==========================================
	// Stimulus and observed signals
	// ==========================================
	logic                     clk = 1'b0;
	logic                     rstn = 1'b0;
	srl_pkg::srl_flash_word_t flash [srl_pkg::NUM_REG];
	logic                     wr = 1'b0;
	logic                     rd = 1'b0;
	logic [7:0]               addr = 8'h00;
	logic [31:0]              wdata = 32'h0000_0000;
	logic                     wake = 1'b1; // Wakeup held high throughout
	logic                     release_core = 1'b0;
	logic                     hold_n;
	logic [7:0]               activity;
	logic [31:0]              rdata;
	logic [15:0]              sub_n;
	logic                     cache_n, wdog_n, comm_n, nvm_n, sram_n;
	logic                     core_n, boot, wake_cpu, wake_fab;
	logic [31:0]              rv;
	int                       errors = 0;
	int                       n_tests = 0;

	// Image: reg0 bits 8..13 writable, reg1 whole locked, reg3 bit0 locked
	initial begin
		flash[0] = '{init: 16'h0f0f, lock: 16'h3f00};
		flash[1] = '{init: 16'h0000, lock: 16'h0000};
		flash[2] = '{init: 16'h0001, lock: 16'hffff};
		flash[3] = '{init: 16'h0003, lock: 16'hfffe};
	end

	always #5 clk = ~clk;

	srl_top i_srl_top (.i_clk(clk), .i_rstn(rstn), .i_flash(flash), .i_processor_hold_reset_n(hold_n),
		.i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_subblock_rst_n(sub_n),
		.o_cache_rst_n(cache_n), .o_watchdog_rst_n(wdog_n), .o_comm_block_rst_n(comm_n),
		.o_nvm_rst_n(nvm_n), .o_sram_rst_n(sram_n), .o_core_rst_n(core_n), .o_core_boot(boot),
		.i_rtc_wakeup(wake), .o_rtc_wake_cpu(wake_cpu), .o_rtc_wake_fab(wake_fab));
	srl_fabric_model i_srl_fabric_model (.i_clk(clk), .i_rstn(rstn), .i_release(release_core),
		.i_core_rst_n(core_n), .i_core_boot(boot), .o_hold_n(hold_n), .o_activity(activity));

	// ==========================================
	// Compare, bus and reset tasks
	// ==========================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One-cycle write strobe, checked one ns after the taking edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : bus_wr
	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd
	task automatic do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		#1 chk(32'({sub_n, comm_n, core_n}), 32'h0);
		@(posedge clk);
		rstn <= 1'b1;
		#1 chk(32'({nvm_n, sram_n, comm_n}), 32'h7);
		@(posedge clk);
		#1 chk(32'(sub_n), 32'h0f0f);
		chk(32'({cache_n, wdog_n}), 32'h1);
	endtask : do_reset

	// ==========================================
	// Scenarios
	// ==========================================
	task automatic t_lock();
		bus_wr(8'h00, 32'h0000_ffff);
		chk(32'(sub_n), 32'h3f0f);
		bus_rd(8'h00, rv);
		chk(rv, 32'h3f0f);
		bus_wr(8'h00, 32'h0);
		chk(32'(sub_n), 32'h000f);
		bus_wr(8'h04, 32'h1);
		chk(32'(cache_n), 32'h0);
		bus_wr(8'h08, 32'h0);
		chk(32'(wdog_n), 32'h0);
		bus_rd(8'h10, rv);
		chk(rv, 32'h00ff_3f00);
		bus_wr(8'h40, 32'hffff_ffff);
		bus_rd(8'h40, rv);
		chk(rv, 32'h0);
	endtask : t_lock
	task automatic t_rtc();
		chk(32'({wake_cpu, wake_fab}), 32'h0);
		bus_wr(8'h0c, 32'h0);
		chk(32'({wake_cpu, wake_fab}), 32'h1);
		bus_rd(8'h0c, rv);
		chk(rv, 32'h1);
	endtask : t_rtc
	task automatic t_core();
		repeat (30) @(posedge clk);
		#1 chk(32'({core_n, activity}), 32'h0);
		@(posedge clk);
		release_core <= 1'b1;
		@(posedge clk);
		#1 chk(32'({core_n, boot}), 32'h3);
		@(posedge clk);
		#1 chk(32'({boot, activity}), 32'h1);
		bus_rd(8'h14, rv);
		chk(rv, 32'h3);
		// Hold drops on a clock edge; the core follows one edge later
		@(posedge clk);
		release_core <= 1'b0;
		@(posedge clk);
		#1 chk(32'(core_n), 32'h0);
	endtask : t_core
	// Hold released during reset must still be ignored until init ends
	task automatic t_init_hold();
		@(posedge clk);
		release_core <= 1'b1;
		do_reset();
		repeat (20) begin
			@(posedge clk);
			#1 chk(32'(core_n), 32'h0);
		end
		@(posedge clk);
		#1 chk(32'(core_n), 32'h1);
	endtask : t_init_hold

	task automatic report_and_stop();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	// Roughly 125 cycles expected; generous margin for a hang
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		do_reset();
		t_lock();
		t_rtc();
		t_core();
		t_init_hold();
		report_and_stop();
	end
endmodule : srl_top_tb_top

/* File: logic/srl_pkg.sv */
// Package for the sub-block reset isolation and lock block.
// Assumes a single 100 MHz clock and a plain register port.
package srl_pkg;

	// ==========================================================
	// Register offsets (byte addresses, one aligned word each)
	// ==========================================================
	localparam logic [7:0] ADDR_SUBBLOCK_RESET  = 8'h00; // Per sub-block hold in reset
	localparam logic [7:0] ADDR_CACHE_CFG       = 8'h04; // Cache control
	localparam logic [7:0] ADDR_WATCHDOG_CFG    = 8'h08; // Watchdog control
	localparam logic [7:0] ADDR_RTC_WAKEUP      = 8'h0c; // RTC wakeup masks
	localparam logic [7:0] ADDR_LOCK_STATUS     = 8'h10; // Read-only lock view
	localparam logic [7:0] ADDR_CORE_STATUS     = 8'h14; // Read-only core state

	// ==========================================================
	// Widths and field positions
	// ==========================================================
	localparam int NUM_SUB        = 16;  // Sub-blocks in the reset register
	localparam int NUM_REG        = 4;   // Writable configuration registers
	localparam int REG_W          = 16;  // Stored width of each register
	localparam int BIT_HIGH_PERF_DMA      = 12;  // High perf dma field
	localparam int BIT_TIMER      = 13;  // Timer field
	localparam int BIT_CACHE_EN   = 0;   // Cache enable in cache_control_cfg
	localparam int BIT_WDOG_EN    = 0;   // Watchdog enable in watchdog_control_cfg
	localparam int BIT_RTC_CPU_M  = 0;   // Wakeup mask toward processor
	localparam int BIT_RTC_FAB_M  = 1;   // Wakeup mask toward fabric

	// ==========================================================
	// Reset values and initialization timing
	// ==========================================================
	localparam logic [3:0] INIT_IDX_LAST = 4'h3;  // Last register index loaded
	localparam int         INIT_TIME_NS  = 200;   // Controller init duration
	localparam int         CLK_PERIOD_NS = 10;
	localparam logic [7:0] INIT_CYCLES   = 8'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,  // Copy flash image into registers
		ST_INIT = 2'b01,  // Controller init, core held
		ST_RUN  = 2'b10   // Normal operation
	} srl_state_t;

	typedef struct packed {
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
		logic [7:0]  addr;   // Byte address
		logic [31:0] wdata;  // Write data
	} srl_bus_req_t;

	typedef struct packed {
		logic [REG_W-1:0] init;  // Power-up value, one word
		logic [REG_W-1:0] lock;  // Per-bit write enable, 1 writable
	} srl_flash_word_t;

endpackage : srl_pkg

/* File: logic/srl_top.sv */
// Sub-block reset isolation with flash-initialized, lockable config registers.
// Assumes flash image ports are static after power-up and inputs are synchronous.
// Operation
// - Disabled sub-blocks held in reset from power-up
// - Reset register has per sub-block fields
// - Locked config keeps disabled blocks in reset
// - DMA and timers default held, software releases
// - Comm block, memories never held in reset
// - Nonvolatile memory never held in reset
// - RTC wakeup maskable, no disable bit
// - RTC wakeup register lockable against upsets
// - Lock bits per register or per field
// - Lock one writable, zero locked
// - Masters cannot overwrite locked registers
// - Core held during init, then follows input
// - Hold reset low keeps core in reset
// - Core runs stored program on release
// - Locked bits continuously forced to init value
// - Registers readable back at run-time
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module srl_top (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	// Flash image, one word per register
	input  wire srl_pkg::srl_flash_word_t i_flash [srl_pkg::NUM_REG],
	// Core hold reset from fabric, active low
	input  wire logic                  i_processor_hold_reset_n,
	// Register port
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	output logic      [31:0]           o_rdata,
	// Sub-block resets, active low
	output logic [srl_pkg::NUM_SUB-1:0] o_subblock_rst_n,
	output logic                       o_cache_rst_n,
	output logic                       o_watchdog_rst_n,
	output logic                       o_comm_block_rst_n,
	output logic                       o_nvm_rst_n,
	output logic                       o_sram_rst_n,
	// Core reset and boot
	output logic                       o_core_rst_n,
	output logic                       o_core_boot,
	// RTC wakeup toward core and fabric
	input  wire logic                  i_rtc_wakeup,
	output logic                       o_rtc_wake_cpu,
	output logic                       o_rtc_wake_fab
);

	// ==========================================================
	// State
	// ==========================================================
	srl_pkg::srl_state_t             state_r, state_nxt;        // Init sequencer
	logic [7:0]                      cnt_r, cnt_nxt;            // Init timer
	logic [srl_pkg::REG_W-1:0]       cfg_r   [srl_pkg::NUM_REG]; // Config registers
	logic [srl_pkg::REG_W-1:0]       cfg_nxt [srl_pkg::NUM_REG];
	logic                            core_run_r, core_run_nxt;  // Core out of reset
	logic                            boot_r, boot_nxt;          // Boot pulse
	logic [31:0]                     rdata_r, rdata_nxt;        // Read data
	logic [1:0]                      widx;                      // Write target index
	logic                            wsel;                      // Write hits a config reg
	srl_pkg::srl_bus_req_t           req;                       // Bundled bus request

	// Bundle the port so decode, read back and checks share one carrier
	assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

	// ==========================================================
	// Sequencer: load flash, hold core through init, then run
	// ==========================================================
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			srl_pkg::ST_LOAD: begin
				state_nxt = srl_pkg::ST_INIT;
				cnt_nxt   = '0;
			end
			srl_pkg::ST_INIT: begin
				// Core held for the whole init window
				if (cnt_r == srl_pkg::INIT_CYCLES - 8'h01) begin
					state_nxt = srl_pkg::ST_RUN;
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
			srl_pkg::ST_RUN: begin
				state_nxt = srl_pkg::ST_RUN;
			end
			default: begin
				state_nxt = srl_pkg::ST_LOAD;
			end
		endcase
	end

	// State and init timer; reset parks in LOAD so the flash copy comes first
	// Registers only; every decision sits in the process above
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= srl_pkg::ST_LOAD;
			cnt_r   <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// ==========================================================
	// Configuration registers
	// ==========================================================
	// Write decode; unmapped and read-only offsets take no write
	always_comb begin
		widx = 2'h0;
		wsel = 1'b0;
		case (req.addr)
			srl_pkg::ADDR_SUBBLOCK_RESET: begin widx = 2'h0; wsel = 1'b1; end
			srl_pkg::ADDR_CACHE_CFG:      begin widx = 2'h1; wsel = 1'b1; end
			srl_pkg::ADDR_WATCHDOG_CFG:   begin widx = 2'h2; wsel = 1'b1; end
			srl_pkg::ADDR_RTC_WAKEUP:     begin widx = 2'h3; wsel = 1'b1; end
			default:                      begin widx = 2'h0; wsel = 1'b0; end
		endcase
	end

	// Per-bit lock: a zero lock bit forces the bit back to its flash value
	// every cycle, so neither a write nor an upset can move it. Whole-register
	// locks are simply all lock bits of that word at zero.
	always_comb begin
		for (int r = 0; r < srl_pkg::NUM_REG; r++) begin
			cfg_nxt[r] = cfg_r[r];
			if (state_r == srl_pkg::ST_LOAD) begin
				cfg_nxt[r] = i_flash[r].init;
			end else begin
				if (req.wr && wsel && (widx == 2'(r))) begin
					// Locked bits keep value, transfer completes normally
					cfg_nxt[r] = (req.wdata[srl_pkg::REG_W-1:0] & i_flash[r].lock)
					           | (cfg_r[r] & ~i_flash[r].lock);
				end
				// Continuous reset or preset of locked bits
				cfg_nxt[r] = (cfg_nxt[r] & i_flash[r].lock)
				           | (i_flash[r].init & ~i_flash[r].lock);
			end
		end
	end

	// Config storage; an all-zero reset value keeps every sub-block held
	// for the one LOAD cycle, which is the safe side to err on
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			// Until flash loads, everything sits held (all zero)
			for (int r = 0; r < srl_pkg::NUM_REG; r++) begin
				cfg_r[r] <= '0;
			end
		end else begin
			for (int r = 0; r < srl_pkg::NUM_REG; r++) begin
				cfg_r[r] <= cfg_nxt[r];
			end
		end
	end

	// ==========================================================
	// Core reset follows hold input only after init
	// ==========================================================
	always_comb begin
		core_run_nxt = (state_r == srl_pkg::ST_RUN) && i_processor_hold_reset_n;
		boot_nxt     = core_run_nxt && !core_run_r;
	end

	// Core state registers; the hold input is sampled every cycle, so a
	// release shows one cycle after the fabric lets go of it
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			core_run_r <= 1'b0;
			boot_r     <= 1'b0;
		end else begin
			core_run_r <= core_run_nxt;
			boot_r     <= boot_nxt;
		end
	end

	// ==========================================================
	// Read back: one cycle after the strobe, only then
	// ==========================================================
	always_comb begin
		rdata_nxt = srl_pkg::RD_ZERO;
		if (req.rd) begin
			case (req.addr)
				srl_pkg::ADDR_SUBBLOCK_RESET: rdata_nxt = {16'h0000, cfg_r[0]};
				srl_pkg::ADDR_CACHE_CFG:      rdata_nxt = {16'h0000, cfg_r[1]};
				srl_pkg::ADDR_WATCHDOG_CFG:   rdata_nxt = {16'h0000, cfg_r[2]};
				srl_pkg::ADDR_RTC_WAKEUP:     rdata_nxt = {16'h0000, cfg_r[3]};
				srl_pkg::ADDR_LOCK_STATUS:    rdata_nxt = {i_flash[1].lock[7:0], i_flash[2].lock[7:0],
				                                           i_flash[0].lock};
				srl_pkg::ADDR_CORE_STATUS:    rdata_nxt = {30'h0, state_r == srl_pkg::ST_RUN,
				                                           core_run_r};
				default:                      rdata_nxt = srl_pkg::RD_ZERO;
			endcase
		end
	end

	// Read data register; cleared when no read so stale data never lingers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Field value 1 releases a sub-block; HIGH_PERF_DMA and timer default to 0 via flash
	assign o_subblock_rst_n   = cfg_r[0];
	assign o_cache_rst_n      = cfg_r[1][srl_pkg::BIT_CACHE_EN];
	assign o_watchdog_rst_n   = cfg_r[2][srl_pkg::BIT_WDOG_EN];
	// No hold option for these: released as soon as reset leaves
	assign o_comm_block_rst_n = i_rstn;
	assign o_sram_rst_n       = i_rstn;
	assign o_nvm_rst_n        = i_rstn;
	// Core reset comes from a flop, so no decode glitch can release it
	assign o_core_rst_n       = core_run_r;
	assign o_core_boot        = boot_r;
	assign o_rdata            = rdata_r;
	// RTC runs always; only its wakeup is masked, mask bit 1 blocks
	assign o_rtc_wake_cpu     = i_rtc_wakeup & ~cfg_r[3][srl_pkg::BIT_RTC_CPU_M];
	assign o_rtc_wake_fab     = i_rtc_wakeup & ~cfg_r[3][srl_pkg::BIT_RTC_FAB_M];

	// ==========================================================
	// Assertions
	// ==========================================================
	core_held_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_r != srl_pkg::ST_RUN) |=> !o_core_rst_n)
		else $error("core left reset during init");
	hold_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!i_processor_hold_reset_n |=> !o_core_rst_n)
		else $error("core released while hold low");
	locked_bits_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_r != srl_pkg::ST_LOAD) |=>
		((cfg_r[0] & ~i_flash[0].lock) == (i_flash[0].init & ~i_flash[0].lock)))
		else $error("locked reset field differs from flash");
	locked_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(req.wr && req.addr == srl_pkg::ADDR_RTC_WAKEUP && state_r != srl_pkg::ST_LOAD) |=>
		((cfg_r[3] & ~i_flash[3].lock) == ($past(cfg_r[3]) & ~i_flash[3].lock)))
		else $error("locked rtc bits changed by write");
	open_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(req.wr && req.addr == srl_pkg::ADDR_WATCHDOG_CFG && state_r != srl_pkg::ST_LOAD) |=>
		((cfg_r[2] & i_flash[2].lock) == ($past(req.wdata[15:0]) & i_flash[2].lock)))
		else $error("unlocked bits did not take write");
	read_back_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(req.rd && req.addr == srl_pkg::ADDR_SUBBLOCK_RESET) |=>
		(o_rdata == {16'h0000, $past(cfg_r[0])}))
		else $error("read back mismatch");
	boot_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_core_rst_n) |-> o_core_boot ##1 !o_core_boot)
		else $error("boot pulse missing on release");
	init_len_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(state_r == srl_pkg::ST_INIT) |-> (state_r == srl_pkg::ST_INIT) [*8] ##1
		(state_r == srl_pkg::ST_INIT) [*8] ##1 (state_r == srl_pkg::ST_INIT) [*4] ##1
		(state_r == srl_pkg::ST_RUN))
		else $error("init window length wrong");
	rtc_mask_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		cfg_r[3][srl_pkg::BIT_RTC_CPU_M] |-> !o_rtc_wake_cpu)
		else $error("masked wakeup reached core");

	// ==========================================================
	// Assertions: configuration registers and read port
	// ==========================================================
	// load_copy_a, rtc_lock_a and unmapped_write_a watch the stored words directly, so a fault in the lock
	// mask or the decode shows up even where no output reflects it.
	// The flash image is static, so comparing against it needs no history.
	load_copy_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_r == srl_pkg::ST_LOAD) |=>
		(cfg_r[0] == i_flash[0].init && cfg_r[1] == i_flash[1].init))
		else $error("flash image not loaded");
	dma_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_r == srl_pkg::ST_LOAD) |=>
		(o_subblock_rst_n[srl_pkg::BIT_HIGH_PERF_DMA] == i_flash[0].init[srl_pkg::BIT_HIGH_PERF_DMA]
		&& o_subblock_rst_n[srl_pkg::BIT_TIMER] == i_flash[0].init[srl_pkg::BIT_TIMER]))
		else $error("dma or timer hold not loaded");
	rtc_lock_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_r != srl_pkg::ST_LOAD) |=>
		((cfg_r[3] & ~i_flash[3].lock) == (i_flash[3].init & ~i_flash[3].lock)))
		else $error("locked rtc mask differs from flash");
	unmapped_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(req.wr && !wsel && state_r != srl_pkg::ST_LOAD) |=>
		(cfg_r[0] == $past(cfg_r[0]) && cfg_r[2] == $past(cfg_r[2])))
		else $error("unmapped write changed a register");
	rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!req.rd |=> (o_rdata == srl_pkg::RD_ZERO))
		else $error("read data stood without a read");
	fab_mask_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		cfg_r[3][srl_pkg::BIT_RTC_FAB_M] |-> !o_rtc_wake_fab)
		else $error("masked wakeup reached fabric");
	fab_pass_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rtc_wakeup && !cfg_r[3][srl_pkg::BIT_RTC_FAB_M]) |-> o_rtc_wake_fab)
		else $error("unmasked wakeup lost toward fabric");

	// ==========================================================
	// Assertions: core reset and always-on resets
	// ==========================================================
	// The core may only leave reset in RUN, one cycle after the hold input
	// is seen high, and the boot strobe marks exactly that edge.
	core_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_r == srl_pkg::ST_RUN) |=> (o_core_rst_n == $past(i_processor_hold_reset_n)))
		else $error("core reset did not follow hold input");
	boot_edge_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_core_boot |-> (o_core_rst_n && !$past(o_core_rst_n)))
		else $error("boot pulse without core release");
	always_on_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_comm_block_rst_n && o_sram_rst_n && o_nvm_rst_n)
		else $error("always-on block held in reset");

endmodule : srl_top
